// File: rtl/cpdc_top.sv
`timescale 1ns/10ps

module cpdc_top
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Processor and wake sources, and the clock source strap
    input  wire logic        i_wfi,
    input  wire logic        i_wake_event,
    input  wire logic [2:0]  i_cfg_clk_src,
    // Clock sources and oscillator stable flags
    input  wire logic [3:0]  i_osc_stable,
    input  wire logic        i_divider_input_clock,
    // Control outputs
    output logic             o_crystal_osc_enable,
    output logic             o_fast_rc_enable,
    output logic             o_slow_rc_enable,
    output logic             o_pll_enable,
    output logic             o_sys_clk_enable,
    output logic             o_cpu_clk_enable,
    output logic [2:0]       o_sys_clk_select,
    output logic [2:0]       o_tick_source,
    output logic             o_periph_clk_enable,
    output logic             o_wdt_clk_enable,
    output logic             o_wake_irq,
    output logic             o_clock_output_pin,
    output logic             o_powered_down
);

    cpdc_pkg::cpdc_state_t st;
    cpdc_pkg::cpdc_state_t next_st;

    logic       wr_acc;
    logic       rd_acc;
    logic       mapped;
    logic       wfi_s;
    logic       wake_s;
    logic [7:0] ofs;

    assign ofs    = paddr[7:0];
    assign mapped = (paddr[11:8] == 4'h0) && (ofs <= cpdc_pkg::OFS_SLEEP) && (ofs[1:0] == 2'h0);
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign wfi_s  = st.wfi_sync[1];
    assign wake_s = st.wake_sync[1];

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb
    begin
        next_st           = st;
        next_st.wfi_sync  = {st.wfi_sync[0], i_wfi};
        next_st.wake_sync = {st.wake_sync[0], i_wake_event};
        next_st.stb_sync  = {st.stb_sync[3:0], i_osc_stable};

        // The crystal bit takes its strap value in the first cycle after reset.
        if (!st.cfg_done)
        begin
            next_st.cfg_done = 1'b1;
            next_st.xtl_en   = (i_cfg_clk_src == cpdc_pkg::CFG_XTL);
        end

        // Register writes.
        if (wr_acc)
        begin
            if (ofs == cpdc_pkg::OFS_PROT)
            begin
                next_st.unlocked = 1'b0;
                case (st.key_step)
                    2'h0: next_st.key_step = (pwdata[7:0] == cpdc_pkg::KEY_1) ? 2'h1 : 2'h0;
                    2'h1: next_st.key_step = (pwdata[7:0] == cpdc_pkg::KEY_2) ? 2'h2 : 2'h0;
                    2'h2:
                    begin
                        next_st.key_step = 2'h0;
                        next_st.unlocked = (pwdata[7:0] == cpdc_pkg::KEY_3);
                    end
                    default: next_st.key_step = 2'h0;
                endcase
            end
            else
            begin
                next_st.key_step = 2'h0;
            end
            case (ofs)
                cpdc_pkg::OFS_PWR:
                begin
                    if (pwdata[cpdc_pkg::B_WST])
                    begin
                        next_st.wst = 1'b0;
                    end
                    if (st.unlocked)
                    begin
                        next_st.xtl_en   = pwdata[cpdc_pkg::B_XTL];
                        next_st.frc_en   = pwdata[cpdc_pkg::B_FRC];
                        next_st.src_en   = pwdata[cpdc_pkg::B_SRC];
                        next_st.dly_en   = pwdata[cpdc_pkg::B_DLY];
                        next_st.wie      = pwdata[cpdc_pkg::B_WIE];
                        next_st.pde      = pwdata[cpdc_pkg::B_PDE];
                        next_st.wait_cpu = pwdata[cpdc_pkg::B_WAIT];
                    end
                end
                cpdc_pkg::OFS_AHB: next_st.ahb = pwdata;
                cpdc_pkg::OFS_APB:
                begin
                    next_st.apb = st.unlocked ? pwdata
                        : {pwdata[31:1], st.apb[cpdc_pkg::B_WDTEN]};
                end
                cpdc_pkg::OFS_SEL0:
                begin
                    if (st.unlocked)
                    begin
                        next_st.sel0 = pwdata;
                    end
                end
                cpdc_pkg::OFS_SEL1:
                begin
                    next_st.sel1 = st.unlocked ? pwdata : {pwdata[31:2], st.sel1[1:0]};
                end
                cpdc_pkg::OFS_DIVN:  next_st.divn = pwdata;
                cpdc_pkg::OFS_SEL2:  next_st.sel2 = pwdata;
                cpdc_pkg::OFS_PLL:   next_st.pll = pwdata;
                cpdc_pkg::OFS_FRQ:   next_st.frq = pwdata[5:0];
                cpdc_pkg::OFS_SLEEP: next_st.sleep_deep = pwdata[0];
                default: next_st.sleep_deep = st.sleep_deep;
            endcase
        end

        // Power mode sequencing.
        case (st.mode)
            cpdc_pkg::CPDC_RUN:
            begin
                if (st.pde && !st.wait_cpu)
                begin
                    next_st.mode = cpdc_pkg::CPDC_DOWN;
                end
                else if (wfi_s && st.pde && st.wait_cpu && st.sleep_deep)
                begin
                    next_st.mode = cpdc_pkg::CPDC_DOWN;
                end
                else if (wfi_s && !st.pde && !st.sleep_deep)
                begin
                    next_st.mode = cpdc_pkg::CPDC_IDLE;
                end
            end
            cpdc_pkg::CPDC_IDLE:
            begin
                if (!wfi_s || wake_s)
                begin
                    next_st.mode = cpdc_pkg::CPDC_RUN;
                end
            end
            cpdc_pkg::CPDC_DOWN:
            begin
                if (wake_s)
                begin
                    next_st.pde  = 1'b0;
                    next_st.mode = cpdc_pkg::CPDC_WAKE;
                    if (!st.dly_en)
                    begin
                        next_st.dly_cnt = 13'h0001;
                    end
                    else if (st.sel0[2:0] == cpdc_pkg::SEL_FRC)
                    begin
                        next_st.dly_cnt = cpdc_pkg::DLY_FRC;
                    end
                    else
                    begin
                        next_st.dly_cnt = cpdc_pkg::DLY_XTL;
                    end
                end
            end
            cpdc_pkg::CPDC_WAKE:
            begin
                next_st.dly_cnt = st.dly_cnt - 13'h0001;
                if (st.dly_cnt == 13'h0001)
                begin
                    next_st.mode = cpdc_pkg::CPDC_RUN;
                end
            end
            default: next_st.mode = cpdc_pkg::CPDC_RUN;
        endcase

        // The wake flag set wins over a write-one clear in the same cycle.
        if (st.mode == cpdc_pkg::CPDC_DOWN && wake_s && st.wie)
        begin
            next_st.wst = 1'b1;
        end

        // Frequency divider chain.
        if (st.frq[cpdc_pkg::B_DIVEN])
        begin
            next_st.div_run = 1'b1;
        end
        else if (!st.div_out)
        begin
            next_st.div_run = 1'b0;
        end
        if (st.div_run)
        begin
            next_st.div_cnt = st.div_cnt + 16'h0001;
        end
        next_st.div_out = st.div_run && next_st.div_cnt[st.frq[3:0]];

        // Read data is captured in the setup cycle.
        if (rd_acc)
        begin
            case (ofs)
                cpdc_pkg::OFS_PWR:
                begin
                    next_st.prdata = {23'h0, st.wait_cpu, st.pde, st.wst, st.wie,
                        st.dly_en, st.src_en, st.frc_en, 1'b0, st.xtl_en};
                end
                cpdc_pkg::OFS_AHB:    next_st.prdata = st.ahb;
                cpdc_pkg::OFS_APB:    next_st.prdata = st.apb;
                cpdc_pkg::OFS_STATUS: next_st.prdata = {27'h0, st.stb_sync[6], st.stb_sync[7],
                    st.stb_sync[5], 1'b0, st.stb_sync[4]};
                cpdc_pkg::OFS_SEL0:   next_st.prdata = st.sel0;
                cpdc_pkg::OFS_SEL1:   next_st.prdata = st.sel1;
                cpdc_pkg::OFS_DIVN:   next_st.prdata = st.divn;
                cpdc_pkg::OFS_SEL2:   next_st.prdata = st.sel2;
                cpdc_pkg::OFS_PLL:    next_st.prdata = st.pll;
                cpdc_pkg::OFS_FRQ:    next_st.prdata = {26'h0, st.frq};
                cpdc_pkg::OFS_PROT:   next_st.prdata = {31'h0, st.unlocked};
                cpdc_pkg::OFS_SLEEP:  next_st.prdata = {31'h0, st.sleep_deep};
                default:              next_st.prdata = 32'h0;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st          <= '0;
            st.src_en   <= cpdc_pkg::RST_PWR[cpdc_pkg::B_SRC];
            st.dly_en   <= cpdc_pkg::RST_PWR[cpdc_pkg::B_DLY];
            st.frc_en   <= 1'b1;
            st.ahb      <= cpdc_pkg::RST_AHB;
            st.apb      <= cpdc_pkg::RST_APB;
            st.sel0     <= cpdc_pkg::RST_SEL0;
            st.sel1     <= cpdc_pkg::RST_SEL1;
            st.divn     <= cpdc_pkg::RST_DIVN;
            st.sel2     <= cpdc_pkg::RST_SEL2;
            st.pll      <= cpdc_pkg::RST_PLL;
            st.frq      <= cpdc_pkg::RST_FRQ[5:0];
            st.mode     <= cpdc_pkg::CPDC_RUN;
        end
        else
        begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    logic down;
    logic run;
    assign down = (st.mode == cpdc_pkg::CPDC_DOWN);
    assign run  = (st.mode == cpdc_pkg::CPDC_RUN) || (st.mode == cpdc_pkg::CPDC_IDLE);

    assign prdata               = st.prdata;
    assign pready               = 1'b1;
    assign pslverr              = psel && penable && !mapped;
    assign o_crystal_osc_enable = st.xtl_en && !down;
    assign o_fast_rc_enable     = st.frc_en && !down;
    assign o_slow_rc_enable     = st.src_en;
    assign o_pll_enable         = !down;
    assign o_sys_clk_enable     = run;
    assign o_cpu_clk_enable     = (st.mode == cpdc_pkg::CPDC_RUN);
    assign o_sys_clk_select     = st.sel0[2:0];
    assign o_tick_source        = st.sel0[cpdc_pkg::B_TKSEL +: 3];
    assign o_periph_clk_enable  = run;
    assign o_wdt_clk_enable     = st.apb[cpdc_pkg::B_WDTEN]
        && (run || st.sel1[1:0] == cpdc_pkg::WDT_SLOW);
    assign o_wake_irq           = st.wst && st.wie;
    assign o_clock_output_pin   = st.frq[cpdc_pkg::B_BYP] ? i_divider_input_clock
        : st.div_out;
    assign o_powered_down       = down;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    property p_irq;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (down && wake_s && st.wie) |=> o_wake_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("wake irq mismatch");

    property p_imm;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (run && st.mode == cpdc_pkg::CPDC_RUN && st.pde && !st.wait_cpu) |=> down;
    endproperty
    a_imm: assert property (p_imm) else $error("no immediate power-down");

    property p_osc;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        down |-> (!o_crystal_osc_enable && !o_fast_rc_enable && !o_sys_clk_enable);
    endproperty
    a_osc: assert property (p_osc) else $error("clock on in power-down");

    property p_clr;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (down && wake_s) |=> (!st.pde && st.mode == cpdc_pkg::CPDC_WAKE);
    endproperty
    a_clr: assert property (p_clr) else $error("enable not cleared");

    property p_flag;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (down && wake_s && st.wie) |=> st.wst;
    endproperty
    a_flag: assert property (p_flag) else $error("wake flag lost");

    property p_dly;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (down && wake_s && st.dly_en && st.sel0[2:0] == cpdc_pkg::SEL_FRC)
            |=> !o_sys_clk_enable [*8];
    endproperty
    a_dly: assert property (p_dly) else $error("wake delay too short");

    property p_lock;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (wr_acc && ofs == cpdc_pkg::OFS_SEL0 && !st.unlocked) |=> $stable(st.sel0);
    endproperty
    a_lock: assert property (p_lock) else $error("protected write took");

    property p_abort;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (wr_acc && ofs != cpdc_pkg::OFS_PROT) |=> st.key_step == 2'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("unlock not aborted");

    property p_idle;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        (st.mode == cpdc_pkg::CPDC_RUN && wfi_s && !st.pde && !st.sleep_deep)
            |=> (!o_cpu_clk_enable && o_sys_clk_enable);
    endproperty
    a_idle: assert property (p_idle) else $error("idle entry wrong");

endmodule // cpdc_top

// File: rtl/cpdc_pkg.sv
package cpdc_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_PWR      = 8'h00;
    localparam logic [7:0] OFS_AHB      = 8'h04;
    localparam logic [7:0] OFS_APB      = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;
    localparam logic [7:0] OFS_SEL0     = 8'h10;
    localparam logic [7:0] OFS_SEL1     = 8'h14;
    localparam logic [7:0] OFS_DIVN     = 8'h18;
    localparam logic [7:0] OFS_SEL2     = 8'h1c;
    localparam logic [7:0] OFS_PLL      = 8'h20;
    localparam logic [7:0] OFS_FRQ      = 8'h24;
    localparam logic [7:0] OFS_PROT     = 8'h28;
    localparam logic [7:0] OFS_SLEEP    = 8'h2c;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int B_XTL    = 0;
    localparam int B_FRC    = 2;
    localparam int B_SRC    = 3;
    localparam int B_DLY    = 4;
    localparam int B_WIE    = 5;
    localparam int B_WST    = 6;
    localparam int B_PDE    = 7;
    localparam int B_WAIT   = 8;
    localparam int B_DIVEN  = 4;
    localparam int B_BYP    = 5;
    localparam int B_TICK   = 2;
    localparam int B_TKSEL  = 3;
    localparam int B_WDTEN  = 0;

    // -----------------------------------------------------------------
    // Reset values and codes
    // -----------------------------------------------------------------
    localparam logic [31:0] RST_PWR  = 32'h0000_0018;
    localparam logic [31:0] RST_AHB  = 32'h0000_000d;
    localparam logic [31:0] RST_APB  = 32'h0000_0001;
    localparam logic [31:0] RST_SEL0 = 32'h0000_003f;
    localparam logic [31:0] RST_SEL1 = 32'hffff_ffff;
    localparam logic [31:0] RST_DIVN = 32'h0000_0000;
    localparam logic [31:0] RST_SEL2 = 32'h0000_00ff;
    localparam logic [31:0] RST_PLL  = 32'h0005_c22e;
    localparam logic [31:0] RST_FRQ  = 32'h0000_0000;
    localparam logic [2:0]  CFG_XTL  = 3'h0;
    localparam logic [1:0]  WDT_SLOW = 2'h3;
    localparam logic [7:0]  KEY_1    = 8'h59;
    localparam logic [7:0]  KEY_2    = 8'h16;
    localparam logic [7:0]  KEY_3    = 8'h88;
    localparam logic [2:0]  SEL_XTL  = 3'h0;
    localparam logic [2:0]  SEL_PLL  = 3'h2;
    localparam logic [2:0]  SEL_SLOW = 3'h3;
    localparam logic [2:0]  SEL_FRC  = 3'h7;
    localparam logic [2:0]  TK_XTL   = 3'h0;
    localparam logic [2:0]  TK_XTL2  = 3'h2;
    localparam logic [2:0]  TK_SYS2  = 3'h3;
    localparam logic [2:0]  TK_FRC2  = 3'h7;
    localparam logic [12:0] DLY_XTL  = 13'h1000;
    localparam logic [12:0] DLY_FRC  = 13'h0100;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {CPDC_RUN, CPDC_IDLE, CPDC_DOWN, CPDC_WAKE} cpdc_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cpdc_apb_req_t;

    typedef struct packed {
        logic [1:0] key_step;
        logic       unlocked;
        logic       xtl_en;
        logic       frc_en;
        logic       src_en;
        logic       dly_en;
        logic       wie;
        logic       wst;
        logic       pde;
        logic       wait_cpu;
        logic [31:0] ahb;
        logic [31:0] apb;
        logic [31:0] sel0;
        logic [31:0] sel1;
        logic [31:0] divn;
        logic [31:0] sel2;
        logic [31:0] pll;
        logic [5:0]  frq;
        logic        sleep_deep;
        cpdc_mode_t  mode;
        logic [12:0] dly_cnt;
        logic [15:0] div_cnt;
        logic        div_run;
        logic        div_out;
        logic        cfg_done;
        logic [31:0] prdata;
        logic [1:0]  wfi_sync;
        logic [1:0]  wake_sync;
        logic [7:0]  stb_sync;
    } cpdc_state_t;

endpackage

// File: tb/cpdc_core_model.sv
`timescale 1ns/10ps
module cpdc_core_model
(
    // Clock, reset, bench requests and the block's power-down status
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    input  wire logic i_sleep,
    input  wire logic i_wake,
    input  wire logic i_powered_down,
    // Sleep and wake lines to the block
    output logic      o_wfi,
    output logic      o_wake_event
);
    // The core sleeps until a wake source fires; a source holds until power-down ends.
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_wfi        <= 1'b0;
            o_wake_event <= 1'b0;
        end
        else
        begin
            if (i_sleep)
                o_wfi <= 1'b1;
            else if (o_wake_event)
                o_wfi <= 1'b0;
            if (i_wake)
                o_wake_event <= 1'b1;
            else if (!i_powered_down)
                o_wake_event <= 1'b0;
        end
    end
endmodule // cpdc_core_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic        clk, rst_b, psel, penable, pwrite, slp, wak, pready, slv, sv;
    logic        dvi = 1'b0;
    logic        wait_for_interrupt_instruction, wev, xtl, frc, slow, pll, sys, cpu, per, wdt, irq, clock_output_pin, pdn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [2:0]  ssel, tsel;
    int          err_total, tests_run, n, cyc;
    logic [7:0]  ofs [6] = '{8'h04, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    logic [31:0] rst [6] = '{cpdc_pkg::RST_AHB, cpdc_pkg::RST_SEL1, cpdc_pkg::RST_DIVN,
                             cpdc_pkg::RST_SEL2, cpdc_pkg::RST_PLL, cpdc_pkg::RST_FRQ};
    logic [2:0]  cd [4] = '{3'h0, 3'h2, 3'h3, 3'h7};

    cpdc_core_model core (.i_ref_clk(clk), .i_rst_b(rst_b), .i_sleep(slp), .i_wake(wak),
        .i_powered_down(pdn), .o_wfi(wait_for_interrupt_instruction), .o_wake_event(wev));
    cpdc_top dut (.i_ref_clk(clk), .i_rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(slv), .i_wfi(wait_for_interrupt_instruction), .i_wake_event(wev), .i_cfg_clk_src(3'h0),
        .i_osc_stable(4'hf), .i_divider_input_clock(dvi), .o_crystal_osc_enable(xtl),
        .o_fast_rc_enable(frc), .o_slow_rc_enable(slow), .o_pll_enable(pll),
        .o_sys_clk_enable(sys), .o_cpu_clk_enable(cpu), .o_sys_clk_select(ssel),
        .o_tick_source(tsel), .o_periph_clk_enable(per), .o_wdt_clk_enable(wdt),
        .o_wake_irq(irq), .o_clock_output_pin(clock_output_pin), .o_powered_down(pdn));

    // ----------------------------------------------------------------
    // Bus tasks and checks
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {4'h0, a}; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 20) err_total++;
        rv = prdata;
        sv = slv;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task unlock;
        apb(1'b1, cpdc_pkg::OFS_PROT, 32'h59);
        apb(1'b1, cpdc_pkg::OFS_PROT, 32'h16);
        apb(1'b1, cpdc_pkg::OFS_PROT, 32'h88);
    endtask
    task wake;
        repeat (4) @(posedge clk);
        wak <= 1'b1;
        @(posedge clk);
        wak <= 1'b0;
        cyc = 0;
        while (cpu !== 1'b1 && cyc < 5000)
        begin
            cyc++;
            @(posedge clk);
        end
        if (cyc >= 5000) err_total++;
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) dvi <= ~dvi;
    initial
    begin
        #(25 * 30000);
        err_total++;
        $display("watchdog expired");
        tally_and_finish;
    end
    initial
    begin
        rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        slp = 0; wak = 0; err_total = 0; tests_run = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk("crystal enable", 1, xtl);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, ofs[i], 0);
            chk("reset value", rst[i], rv);
        end
        apb(1'b0, cpdc_pkg::OFS_STATUS, 0);
        chk("clock status", 32'h0000_001d, rv);
        chk("mapped no error", 0, sv);
        apb(1'b0, 8'h30, 0);
        chk("unmapped data", 0, rv);
        chk("unmapped error", 1, sv);
        apb(1'b1, cpdc_pkg::OFS_PWR, 32'h80);
        apb(1'b1, cpdc_pkg::OFS_SEL0, 32'h12);
        repeat (2) @(posedge clk);
        chk("locked power-down", 0, pdn);
        chk("locked select", cpdc_pkg::RST_SEL0[5:0], {tsel, ssel});
        apb(1'b1, cpdc_pkg::OFS_PROT, 32'h59);
        apb(1'b1, cpdc_pkg::OFS_PROT, 32'h16);
        apb(1'b1, cpdc_pkg::OFS_AHB, cpdc_pkg::RST_AHB);
        apb(1'b1, cpdc_pkg::OFS_PROT, 32'h88);
        apb(1'b0, cpdc_pkg::OFS_PROT, 0);
        chk("aborted unlock", 0, rv[0]);
        unlock;
        apb(1'b0, cpdc_pkg::OFS_PROT, 0);
        chk("unlocked", 1, rv[0]);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, cpdc_pkg::OFS_SEL0, {26'h0, cd[3 - i], cd[i]});
            chk("system select", cd[i], ssel);
            chk("tick select", cd[3 - i], tsel);
        end
        $display("test reset, protection and selects done");
        apb(1'b1, cpdc_pkg::OFS_PWR, 32'had);
        repeat (3) @(posedge clk);
        chk("immediate down", 1, pdn);
        chk("osc off", 0, {xtl, frc});
        chk("slow on", 1, slow);
        chk("pll sys off", 0, {pll, sys});
        chk("periph off", 0, per);
        chk("wdt slow on", 1, wdt);
        wake;
        chk("wake fast", 1, cyc <= 8);
        chk("osc back", 3, {xtl, frc});
        chk("wake irq", 1, irq);
        apb(1'b0, cpdc_pkg::OFS_PWR, 0);
        chk("enable and flag", 2'h1, rv[7:6]);
        apb(1'b1, cpdc_pkg::OFS_PWR, 32'h6d);
        apb(1'b0, cpdc_pkg::OFS_PWR, 0);
        chk("flag clear", 0, {rv[6], irq});
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, cpdc_pkg::OFS_SEL0, i ? 32'h3f : 32'h38);
            apb(1'b1, cpdc_pkg::OFS_PWR, 32'h9d);
            wake;
            n = i ? cpdc_pkg::DLY_FRC : cpdc_pkg::DLY_XTL;
            chk("wake delay", 1, cyc >= n && cyc <= n + 8);
            apb(1'b0, cpdc_pkg::OFS_PWR, 0);
            chk("no flag", 0, rv[6]);
        end
        $display("test power-down and wake done");
        apb(1'b1, cpdc_pkg::OFS_SLEEP, 1);
        apb(1'b1, cpdc_pkg::OFS_PWR, 32'h18d);
        repeat (2) @(posedge clk);
        chk("waits for core", 0, pdn);
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        repeat (4) @(posedge clk);
        chk("down on sleep", 1, pdn);
        wake;
        apb(1'b1, cpdc_pkg::OFS_SLEEP, 0);
        apb(1'b1, cpdc_pkg::OFS_PWR, 32'h10d);
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        repeat (4) @(posedge clk);
        chk("idle", 3'h2, {cpu, sys, pdn});
        wake;
        chk("idle exit", 1, cpu);
        $display("test sleep modes done");
        apb(1'b1, cpdc_pkg::OFS_FRQ, 32'h20);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clk);
            chk("bypass", dvi, clock_output_pin);
        end
        @(posedge clk);
        apb(1'b1, cpdc_pkg::OFS_FRQ, 32'h10);
        n = 0;
        repeat (16) @(negedge clk) n += clock_output_pin;
        chk("divider runs", 8, n);
        @(posedge clk);
        apb(1'b1, cpdc_pkg::OFS_FRQ, 32'h11);
        n = 0;
        rv[0] = clock_output_pin;
        repeat (16)
        begin
            @(negedge clk);
            n += (clock_output_pin != rv[0]);
            rv[0] = clock_output_pin;
        end
        chk("divider tap", 1, n >= 6 && n <= 10);
        @(posedge clk);
        apb(1'b1, cpdc_pkg::OFS_FRQ, 32'h0);
        repeat (4) @(posedge clk);
        n = 0;
        repeat (16) @(negedge clk) n += clock_output_pin;
        chk("divider stopped low", 0, n);
        $display("test divider done");
        tally_and_finish;
    end
endmodule // tb_top
